/* rtl/wsd_wheel_slide.v */
/*
  wsd_wheel_slide: top of the wheel slide detector. Four axle sensor
  pulse inputs, two truck dump outputs, register port and interrupt.
  Sensor inputs are asynchronous pins; axles 0,1 on truck 0, axles 2,3
  on truck 1. Register port: one-cycle strobes, read data next cycle.
*/
// Strobed register access and the address map are this design's own decisions.
`include "wsd_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module wsd_wheel_slide #(
  parameter DUMP_CYCLES   = `WSD_DUMP_CYCLES,
  parameter SAMPLE_CYCLES = `WSD_SAMPLE_CYCLES
) (
  input  wire       clock,
  input  wire       rst,
  input  wire [3:0] axlePulse,
  input  wire [3:0] addr,
  input  wire [7:0] wrData,
  input  wire       wrStb,
  input  wire       rdStb,
  output reg  [7:0] rdData,
  output reg  [1:0] dumpValve,
  output reg        irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_DUMP = 3'b010;
  localparam ST_TRIP = 3'b100;

  reg  [3:0]  sync1_r;
  reg  [3:0]  sync2_r;
  reg  [3:0]  syncOld_r;
  wire [3:0]  pulseEv;
  wire [3:0]  slide;
  reg  [7:0]  trim_r;
  reg  [7:0]  decelLim_r;
  reg  [6:0]  status_r;
  reg  [6:0]  mask_r;
  reg  [31:0] sampleCnt_r;
  reg  [7:0]  rateCnt_r;
  reg  [7:0]  lastRate_r;
  reg         decelSlide_r;
  reg  [4:0]  slideOld_r;
  wire [1:0]  dumpReq;
  wire [1:0]  tripEv;
  wire        sampleTick;
  wire [6:0]  events;

  // first stage feeds only the second
  always @(posedge clock) begin
    if (rst) begin
      sync1_r   <= 4'h0;
      sync2_r   <= 4'h0;
      syncOld_r <= 4'h0;
    end else begin
      sync1_r   <= axlePulse;
      sync2_r   <= sync1_r;
      syncOld_r <= sync2_r;
    end
  end

  assign pulseEv = sync2_r & ~syncOld_r;

  // ring of pairs: axle i compared against reference axle i+1
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gPair
      wsd_pair_detector uPair (
        .clock    (clock),
        .rst      (rst),
        .refPulse (pulseEv[(g + 1) % 4]),
        .cmpPulse (pulseEv[g]),
        .refTrim  (trim_r[2 * ((g + 1) % 4) +: 2]),
        .cmpTrim  (trim_r[2 * g +: 2]),
        .slide    (slide[g])
      );
    end
  endgenerate

  // deceleration of axle 0 by rate drop per window
  assign sampleTick = (sampleCnt_r == SAMPLE_CYCLES - 1);

  always @(posedge clock) begin
    if (rst) begin
      sampleCnt_r  <= 32'h0;
      rateCnt_r    <= 8'h00;
      lastRate_r   <= 8'h00;
      decelSlide_r <= 1'b0;
    end else begin
      if (sampleTick) begin
        sampleCnt_r <= 32'h0;
        rateCnt_r   <= {7'h00, pulseEv[0]};
        lastRate_r  <= rateCnt_r;
        decelSlide_r <= (lastRate_r > rateCnt_r) &&
                        (lastRate_r - rateCnt_r > decelLim_r);
      end else begin
        sampleCnt_r <= sampleCnt_r + 32'h1;
        if (pulseEv[0] && rateCnt_r != 8'hFF) begin
          rateCnt_r <= rateCnt_r + 8'h01;
        end
      end
    end
  end

  assign dumpReq[0] = slide[0] | slide[1] | decelSlide_r;
  assign dumpReq[1] = slide[2] | slide[3];

  generate
    for (g = 0; g < 2; g = g + 1) begin : gTruck
      reg [2:0]  st_r;
      reg [31:0] tmr_r;
      assign tripEv[g] = (st_r == ST_DUMP) && dumpReq[g] && (tmr_r == DUMP_CYCLES - 1);
      always @(posedge clock) begin
        if (rst) begin
          st_r         <= ST_IDLE;
          tmr_r        <= 32'h0;
          dumpValve[g] <= 1'b0;
        end else begin
          case (st_r)
            ST_IDLE: begin
              tmr_r <= 32'h0;
              if (dumpReq[g]) begin
                st_r         <= ST_DUMP;
                dumpValve[g] <= 1'b1;
              end
            end
            ST_DUMP: begin
              if (!dumpReq[g]) begin
                st_r         <= ST_IDLE;
                tmr_r        <= 32'h0;
                dumpValve[g] <= 1'b0;
              end else if (tripEv[g]) begin
                st_r         <= ST_TRIP;
                dumpValve[g] <= 1'b0;
              end else begin
                tmr_r <= tmr_r + 32'h1;
              end
            end
            ST_TRIP: begin
              dumpValve[g] <= 1'b0;
              tmr_r        <= 32'h0;
              if (!dumpReq[g]) begin
                st_r <= ST_IDLE;
              end
            end
            default: begin
              st_r         <= ST_IDLE;
              dumpValve[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  // events rise-detected so a held slide counts once and can be cleared
  always @(posedge clock) begin
    if (rst) begin
      slideOld_r <= 5'h00;
    end else begin
      slideOld_r <= {decelSlide_r, slide};
    end
  end

  assign events = {tripEv, {decelSlide_r, slide} & ~slideOld_r};

  // set wins over a write-one clear in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      status_r   <= 7'h00;
      mask_r     <= `WSD_MASK_RST;
      trim_r     <= `WSD_TRIM_RST;
      decelLim_r <= `WSD_DECEL_LIMIT_RST;
      rdData     <= 8'h00;
      irq        <= 1'b0;
    end else begin
      status_r <= (status_r & ~((wrStb && addr == `WSD_ADDR_STATUS) ? wrData[6:0] : 7'h00))
                  | events;
      if (wrStb) begin
        case (addr)
          `WSD_ADDR_MASK:  mask_r     <= wrData[6:0];
          `WSD_ADDR_TRIM:  trim_r     <= wrData;
          `WSD_ADDR_DECEL: decelLim_r <= wrData;
          default: ;
        endcase
      end
      if (rdStb) begin
        case (addr)
          `WSD_ADDR_STATUS: rdData <= {1'b0, status_r};
          `WSD_ADDR_MASK:   rdData <= {1'b0, mask_r};
          `WSD_ADDR_TRIM:   rdData <= trim_r;
          `WSD_ADDR_DECEL:  rdData <= decelLim_r;
          `WSD_ADDR_STATE:  rdData <= {1'b0, decelSlide_r, dumpValve, slide};
          `WSD_ADDR_RATE:   rdData <= lastRate_r;
          default:          rdData <= 8'h00;
        endcase
      end else begin
        rdData <= 8'h00;
      end
      irq <= |(status_r & mask_r);
    end
  end

endmodule // wsd_wheel_slide

`default_nettype wire

/* rtl/wsd_regs.vh */
/*
  wsd_regs.vh: constants of the wheel slide detector, including the
  register offsets, field positions, reset values and timing counts.
  Assumes a 50 MHz system clock.
*/
`ifndef WSD_REGS_VH
`define WSD_REGS_VH

`define WSD_CLK_HZ          50000000
`define WSD_REF_TC          6'h3C
`define WSD_CMP_TC          6'h3F
`define WSD_TRIM_A          6'h00
`define WSD_TRIM_B          6'h01
`define WSD_TRIM_C          6'h02
`define WSD_TRIM_D          6'h03
`define WSD_DUMP_TIME_MS    3000
`define WSD_DUMP_CYCLES     (`WSD_DUMP_TIME_MS * (`WSD_CLK_HZ / 1000))
`define WSD_SAMPLE_MS       100
`define WSD_SAMPLE_CYCLES   (`WSD_SAMPLE_MS * (`WSD_CLK_HZ / 1000))
`define WSD_DECEL_LIMIT_RST 8'h08

`define WSD_ADDR_STATUS     4'h0
`define WSD_ADDR_MASK       4'h1
`define WSD_ADDR_TRIM       4'h2
`define WSD_ADDR_DECEL      4'h3
`define WSD_ADDR_STATE      4'h4
`define WSD_ADDR_RATE       4'h5

`define WSD_STAT_SLIDE_LSB  0
`define WSD_STAT_DECEL      4
`define WSD_STAT_TRIP_LSB   5
`define WSD_EV_W            7
`define WSD_MASK_RST        7'h00
`define WSD_TRIM_RST        8'h00

`endif

/* rtl/wsd_pair_detector.v */
/*
  wsd_pair_detector: one fill-up comparison between a reference axle
  and a compared axle. Pulse inputs are single-cycle strobes that are
  already synchronised to the clock.
*/
`include "wsd_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module wsd_pair_detector (
  input  wire       clock,
  input  wire       rst,
  input  wire       refPulse,
  input  wire       cmpPulse,
  input  wire [1:0] refTrim,
  input  wire [1:0] cmpTrim,
  output reg        slide
);

  reg  [5:0] refCnt_r;
  reg  [5:0] cmpCnt_r;
  reg        refFull_r;
  wire [5:0] refTc;
  wire [5:0] cmpTc;

  // larger wheel gives fewer pulses per distance, so its limit drops
  function [5:0] wsdTrim;
    input [5:0] base;
    input [1:0] pos;
    begin
      wsdTrim = base - {4'h0, pos};
    end
  endfunction

  assign refTc = wsdTrim(`WSD_REF_TC, refTrim);
  assign cmpTc = wsdTrim(`WSD_CMP_TC, cmpTrim);

  always @(posedge clock) begin
    if (rst) begin
      refCnt_r  <= 6'h00;
      cmpCnt_r  <= 6'h00;
      refFull_r <= 1'b0;
      slide     <= 1'b0;
    end else if (refFull_r) begin
      // full reference clears both counters and itself
      refCnt_r  <= 6'h00;
      cmpCnt_r  <= 6'h00;
      refFull_r <= 1'b0;
      slide     <= 1'b0;
    end else begin
      if (refPulse && !slide) begin
        refCnt_r <= refCnt_r + 6'h01;
        if (refCnt_r + 6'h01 >= refTc) begin
          refFull_r <= 1'b1;
        end
      end
      if (cmpPulse && !slide) begin
        cmpCnt_r <= cmpCnt_r + 6'h01;
        if (cmpCnt_r + 6'h01 >= cmpTc && !(refPulse && refCnt_r + 6'h01 >= refTc)) begin
          slide <= 1'b1;
        end
      end
      // held until the reference catches up (counting resumes below)
      if (slide && refPulse) begin
        refCnt_r <= refCnt_r + 6'h01;
        if (refCnt_r + 6'h01 >= refTc) begin
          refFull_r <= 1'b1;
        end
      end
    end
  end

endmodule // wsd_pair_detector

`default_nettype wire

/* tb/wsd_axle_model.sv */
/* wsd_axle_model: four axle sensors, 8-cycle pulse period each.
   assumes the bench clock; a stopped axle holds its pin low. */
`timescale 1ns/100ps
`default_nettype none
module wsd_axle_model (
  input  wire logic       clock,
  input  wire logic [3:0] run,
  output var  logic [3:0] pulse = 4'h0
);
  logic [2:0] phase_r = 3'h0;
  logic [3:0] en_r    = 4'h0;
  always @(posedge clock) begin
    phase_r <= phase_r + 3'h1;
    // start or stop only at a period edge, so no runt pulse
    if (phase_r == 3'h7) begin
      en_r <= run;
    end
    pulse <= en_r & {4{phase_r[2]}};
  end
endmodule // wsd_axle_model
`default_nettype wire

/* tb/wsd_wheel_slide_properties.sv */
/* wsd_slide_props: port checks of wsd_wheel_slide.
   assumes one clock and synchronous active-high rst. */
`timescale 1ns/100ps
`default_nettype none
module wsd_slide_props #(
  parameter DUMP_CYCLES   = 50,
  parameter SAMPLE_CYCLES = 200
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [3:0] axlePulse,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrStb,
  input wire logic       rdStb,
  input wire logic [7:0] rdData,
  input wire logic [1:0] dumpValve,
  input wire logic       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // cycles each dump has been on without a break
  int on0_r;
  int on1_r;
  always @(posedge clock) begin
    on0_r <= (rst || !dumpValve[0]) ? 0 : on0_r + 1;
    on1_r <= (rst || !dumpValve[1]) ? 0 : on1_r + 1;
  end
  sequence readState;
    rdStb && addr == 4'h4;
  endsequence
  sequence tripDrop1;
    $fell(dumpValve[1]) && on1_r >= DUMP_CYCLES - 2;
  endsequence
  AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> dumpValve == 2'h0 && !irq)
    else $error("outputs active after reset");
  AST_RD_IDLE: assert property (!rdStb |=> rdData == 8'h00)
    else $error("read data without read strobe");
  AST_RD_UNMAPPED: assert property (rdStb && addr > 4'h5 |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  AST_STATE_DUMP: assert property (readState |=> rdData[7] == 1'b0 && rdData[5:4] == $past(dumpValve))
    else $error("state read disagrees with dump outputs");
  AST_IRQ_MASKED: assert property (wrStb && addr == 4'h1 && wrData == 8'h00 |-> ##2 !irq)
    else $error("interrupt with all masked");
  AST_LIMIT0: assert property (on0_r <= DUMP_CYCLES + 2)
    else $error("truck 0 dump on too long");
  AST_LIMIT1: assert property (on1_r <= DUMP_CYCLES + 2)
    else $error("truck 1 dump on too long");
  AST_TRIP_HOLD: assert property (tripDrop1 |-> !dumpValve[1] [*8])
    else $error("tripped dump came back");
endmodule // wsd_slide_props
bind wsd_wheel_slide wsd_slide_props #(
  .DUMP_CYCLES(DUMP_CYCLES),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_props (
  .clock(clock), .rst(rst), .axlePulse(axlePulse), .addr(addr), .wrData(wrData),
  .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .dumpValve(dumpValve), .irq(irq)
);
`default_nettype wire

/* tb/wsd_wheel_slide_tb.sv */
/* wsd_wheel_slide_tb: register, slide and trip tests.
   assumes wsd_axle_model on the sensor pins. */
`timescale 1ns/100ps
`default_nettype none
module wsd_wheel_slide_tb;
  localparam int DUMP = 1000; // short trip, still longer than one fill
  logic       clock  = 1'b0;
  logic       rst    = 1'b1;
  logic [3:0] addr   = 4'h0;
  logic [7:0] wrData = 8'h00;
  logic       wrStb  = 1'b0;
  logic       rdStb  = 1'b0;
  logic [3:0] run    = 4'hF;
  wire logic [3:0] axlePulse;
  wire logic [7:0] rdData;
  wire logic [1:0] dumpValve;
  wire logic       irq;
  int num_errors = 0;
  int samples_checked = 0;
  always #10 clock = ~clock;
  wsd_axle_model u_axles (.clock(clock), .run(run), .pulse(axlePulse));
  wsd_wheel_slide #(.DUMP_CYCLES(DUMP), .SAMPLE_CYCLES(200)) u_dut (
    .clock(clock), .rst(rst), .axlePulse(axlePulse), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .dumpValve(dumpValve), .irq(irq));
  task stop_test();
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a; wrData <= d; wrStb <= 1'b1;
    @(posedge clock);
    wrStb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a; rdStb <= 1'b1;
    @(posedge clock);
    rdStb <= 1'b0;
    #1 check(rdData, exp);
  endtask
  // bounded wait for one dump output to reach a level
  task waitDump(input int b, input logic lvl, input int lim);
    for (int i = 0; i < lim && dumpValve[b] !== lvl; i++) begin
      @(posedge clock); #1;
    end
    check({7'h0, dumpValve[b]}, {7'h0, lvl});
    if (dumpValve[b] !== lvl) stop_test();
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(4'h3, 8'h08); rd(4'h9, 8'h00); wr(4'h9, 8'hFF); rd(4'h9, 8'h00); rd(4'h1, 8'h00);
    wr(4'h2, 8'hE4); rd(4'h2, 8'hE4); wr(4'h2, 8'h00);
    wr(4'h1, 8'h01);
    repeat (1500) @(posedge clock);
    rd(4'h4, 8'h00);
    run <= 4'hD;
    waitDump(0, 1'b1, 1000);
    check({6'h0, dumpValve}, 8'h01);
    run <= 4'hF;
    waitDump(0, 1'b0, 1000);
    check({7'h0, irq}, 8'h01);
    rd(4'h0, 8'h01); wr(4'h0, 8'h01); rd(4'h0, 8'h00);
    check({7'h0, irq}, 8'h00);
    run <= 4'h7;
    waitDump(1, 1'b1, 1000);
    run <= 4'hF;
    waitDump(1, 1'b0, 1000);
    run <= 4'h7;
    waitDump(1, 1'b1, 1000);
    repeat (DUMP - 10) @(posedge clock);
    #1 check({7'h0, dumpValve[1]}, 8'h01);
    waitDump(1, 1'b0, 30);
    repeat (20) @(posedge clock);
    #1 check({7'h0, dumpValve[1]}, 8'h00);
    rd(4'h0, 8'h44);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h7F);
    // axles 0 to 2 stop together, axle 3 already stopped: only the deceleration watch can see it
    run <= 4'h0;
    waitDump(0, 1'b1, 600);
    waitDump(0, 1'b0, 300);
    rd(4'h0, 8'h10);
    repeat (3) @(posedge clock);
    stop_test();
  end
endmodule // wsd_wheel_slide_tb
`default_nettype wire
